/* hw/occ_pkg.sv */
package occ_pkg;

   // ************************************************************
   // Unlock sequence and reset values
   // ************************************************************
   localparam logic [7:0]  UNLOCK_FIRST    = 8'hE7;
   localparam logic [7:0]  UNLOCK_SECOND   = 8'h18;
   localparam logic [7:0]  PRIMARY_RESET   = 8'hA0;
   localparam logic [7:0]  SECONDARY_RESET = 8'h00;

   // ************************************************************
   // Field positions
   // ************************************************************
   // Primary register: 7 int osc en, 6 ext osc en, 5 wdt osc en,
   // 4 fail det en, 2:0 system clock select
   localparam int INT_EN_BIT     = 7;
   localparam int EXT_EN_BIT     = 6;
   localparam int WDT_EN_BIT     = 5;
   localparam int FAIL_DET_BIT   = 4;
   localparam int SEL_LSB        = 0;
   // Secondary register: 7 secondary osc en
   localparam int SEC_EN_BIT     = 7;

   localparam logic [2:0] SEL_INT = 3'h0;
   localparam logic [2:0] SEL_EXT = 3'h1;
   localparam logic [2:0] SEL_WDT = 3'h3;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int WDT_FAIL_CYCLES = 8004;
   localparam int CORE_CLK_MHZ    = 100;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [2:0] {
      LOCK_IDLE   = 3'b001,
      LOCK_FIRST  = 3'b010,
      LOCK_OPEN   = 3'b100
   } occ_lock_type;

   typedef struct packed {
      logic       int_osc_en;
      logic       ext_osc_en;
      logic       wdt_osc_en;
      logic       fail_det_en;
      logic [2:0] sys_sel;
      logic       sec_osc_en;
   } occ_cfg_type;

   typedef struct packed {
      logic       wr;
      logic       sel_secondary;
      logic [7:0] data;
   } occ_wr_type;

endpackage : occ_pkg

/* hw/occ_wdt_fail.sv */
module occ_wdt_fail #(
   parameter int LIMIT = occ_pkg::WDT_FAIL_CYCLES
) (
   input  wire logic core_clk,
   input  wire logic resetn,
   input  wire logic enable,
   input  wire logic wdt_clk_pin,
   output logic      fail
);

   // Counter sized from the limit so a longer limit cannot wrap early
   localparam int CW = $clog2(LIMIT + 1);

   logic          s1_reg;
   logic          s2_reg;
   logic          s3_reg;
   logic [CW-1:0] cnt_reg;
   logic          edge_seen;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= wdt_clk_pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   assign edge_seen = s2_reg & ~s3_reg;

   // Counts system clocks, so latency scales with clock period [RL5]
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= '0;
         fail    <= 1'b0;
      end else if (!enable || edge_seen) begin
         cnt_reg <= '0;
         fail    <= 1'b0;
      end else if (cnt_reg == CW'(LIMIT - 1)) begin
         fail    <= 1'b1; // [RL5]
      end else begin
         cnt_reg <= cnt_reg + CW'(1);
      end
   end

endmodule : occ_wdt_fail

/* hw/occ_top.sv */
// What this block does
// RL1 - Writes E7H then 18H unlock a control register and are not stored.
// RL2 - Next write after unlock updates the register and relocks.
// RL3 - Any other write sequence leaves register contents unchanged.
// RL4 - Unlock values must come in order; reversed order does not unlock.
// RL5 - Watchdog failure declared after 8004 system clocks without its edge.
// RL6 - Detection off with no working source halts until power-on reset.
// RL7 - Peripheral clock reaches only timers and their noise filters.
// RL8 - Timer on peripheral clock keeps counting in STOP mode.
// RL9 - Software enables secondary oscillator, then selects it in timer.
// RL10 - Registers enable oscillators, failure detection, and select clock.
// RL11 - Software readies watchdog oscillator before selecting it.
// RL12 - Lock state machine starts locked after system reset; only resetn resets it, por_n does not.
module occ_top #(
   parameter int FAIL_CYCLES = occ_pkg::WDT_FAIL_CYCLES
) (
   input  wire logic               core_clk,
   input  wire logic               resetn,
   input  wire logic               por_n,
   input  wire occ_pkg::occ_wr_type bus_wr,
   input  wire logic               wdt_clk_pin,
   input  wire logic               ext_osc_ok,
   input  wire logic               int_osc_ok,
   input  wire logic               stop_mode,
   input  wire logic               timer_periph_sel,
   input  wire logic               periph_clk_pin,
   output logic [7:0]              osc_control_primary,
   output logic [7:0]              osc_control_secondary,
   output occ_pkg::occ_cfg_type    cfg,
   output logic                    wdt_fail,
   output logic                    recover_active,
   output logic                    halted,
   output logic                    timer_periph_tick,
   output logic                    timer_clk_enable
);

   // ************************************************************
   // Unlock state machines, one per register
   // ************************************************************
   occ_pkg::occ_lock_type lock_reg [2];
   logic [1:0]            commit;

   function automatic occ_pkg::occ_lock_type lock_step(
      input occ_pkg::occ_lock_type st,
      input logic [7:0]            d
   );
      occ_pkg::occ_lock_type n;
      n = occ_pkg::LOCK_IDLE;
      case (st)
         occ_pkg::LOCK_IDLE: begin
            n = (d == occ_pkg::UNLOCK_FIRST) ? occ_pkg::LOCK_FIRST
                                              : occ_pkg::LOCK_IDLE;
         end
         occ_pkg::LOCK_FIRST: begin
            // Second write must be 18H; 18H first goes nowhere [RL4]
            if (d == occ_pkg::UNLOCK_SECOND) begin
               n = occ_pkg::LOCK_OPEN;
            end else if (d == occ_pkg::UNLOCK_FIRST) begin
               n = occ_pkg::LOCK_FIRST;
            end else begin
               n = occ_pkg::LOCK_IDLE; // [RL3]
            end
         end
         occ_pkg::LOCK_OPEN: n = occ_pkg::LOCK_IDLE; // [RL2]
         default:            n = occ_pkg::LOCK_IDLE;
      endcase
      return n;
   endfunction : lock_step

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_lock
         logic hit;
         assign hit = bus_wr.wr && (bus_wr.sel_secondary == 1'(gi));
         // Only the write in the open state stores [RL1] [RL3]
         assign commit[gi] = hit && (lock_reg[gi] == occ_pkg::LOCK_OPEN);
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               lock_reg[gi] <= occ_pkg::LOCK_IDLE; // [RL12]
            end else if (hit) begin
               lock_reg[gi] <= lock_step(lock_reg[gi], bus_wr.data);
            end
         end
      end
   endgenerate

   // ************************************************************
   // Control registers
   // ************************************************************
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         osc_control_primary <= occ_pkg::PRIMARY_RESET;
      end else if (commit[0]) begin
         osc_control_primary <= bus_wr.data; // [RL2]
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         osc_control_secondary <= occ_pkg::SECONDARY_RESET;
      end else if (commit[1]) begin
         osc_control_secondary <= bus_wr.data; // [RL2]
      end
   end

   // Field decode [RL10]
   always_comb begin
      cfg.int_osc_en  = osc_control_primary[occ_pkg::INT_EN_BIT];
      cfg.ext_osc_en  = osc_control_primary[occ_pkg::EXT_EN_BIT];
      cfg.wdt_osc_en  = osc_control_primary[occ_pkg::WDT_EN_BIT];
      cfg.fail_det_en = osc_control_primary[occ_pkg::FAIL_DET_BIT];
      cfg.sys_sel     = osc_control_primary[occ_pkg::SEL_LSB +: 3];
      cfg.sec_osc_en  = osc_control_secondary[occ_pkg::SEC_EN_BIT];
   end

   // ************************************************************
   // Failure detection and recovery
   // ************************************************************
   occ_wdt_fail #(
      .LIMIT       (FAIL_CYCLES)
   ) u_wdt_fail (
      .core_clk    (core_clk),
      .resetn      (resetn),
      .enable      (cfg.fail_det_en & cfg.wdt_osc_en),
      .wdt_clk_pin (wdt_clk_pin),
      .fail        (wdt_fail)
   );

   logic ext_s1_reg, ext_ok_reg, int_s1_reg, int_ok_reg;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ext_s1_reg <= 1'b0;
         ext_ok_reg <= 1'b0;
         int_s1_reg <= 1'b0;
         int_ok_reg <= 1'b0;
      end else begin
         ext_s1_reg <= ext_osc_ok;
         ext_ok_reg <= ext_s1_reg;
         int_s1_reg <= int_osc_ok;
         int_ok_reg <= int_s1_reg;
      end
   end

   logic any_working;
   assign any_working = (cfg.int_osc_en & int_ok_reg)
                      | (cfg.ext_osc_en & ext_ok_reg)
                      | (cfg.wdt_osc_en & ~wdt_fail);

   // Recovery to internal osc only while detection is enabled
   assign recover_active = cfg.fail_det_en & cfg.int_osc_en
                         & ((cfg.sys_sel == occ_pkg::SEL_WDT & wdt_fail)
                          | (cfg.sys_sel == occ_pkg::SEL_EXT
                             & ~ext_ok_reg));

   // Halt is sticky: system reset cannot clear it, only power-on [RL6]
   always_ff @(posedge core_clk or negedge por_n) begin
      if (!por_n) begin
         halted <= 1'b0;
      end else if (!cfg.fail_det_en && !any_working) begin
         halted <= 1'b1; // [RL6]
      end
   end

   // ************************************************************
   // Peripheral clock, timers only
   // ************************************************************
   logic pc_s1_reg, pc_s2_reg, pc_s3_reg;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pc_s1_reg <= 1'b0;
         pc_s2_reg <= 1'b0;
         pc_s3_reg <= 1'b0;
      end else begin
         pc_s1_reg <= periph_clk_pin;
         pc_s2_reg <= pc_s1_reg;
         pc_s3_reg <= pc_s2_reg;
      end
   end

   // Single output feeds timer and filter only [RL7]
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         timer_periph_tick <= 1'b0;
      end else begin
         timer_periph_tick <= cfg.sec_osc_en & timer_periph_sel
                            & pc_s2_reg & ~pc_s3_reg; // [RL7]
      end
   end

   // Stop mode gates the timer unless it runs on the peripheral clock
   assign timer_clk_enable = ~stop_mode
                           | (timer_periph_sel & cfg.sec_osc_en); // [RL8]

endmodule : occ_top

/* testbench/occ_top_sva.sv */
module occ_top_sva #(
   parameter int FAIL_CYCLES = occ_pkg::WDT_FAIL_CYCLES
) (
   input wire logic                 core_clk,
   input wire logic                 resetn,
   input wire logic                 por_n,
   input wire occ_pkg::occ_wr_type  bus_wr,
   input wire logic                 wdt_clk_pin,
   input wire logic [7:0]           osc_control_primary,
   input wire logic [7:0]           osc_control_secondary,
   input wire occ_pkg::occ_cfg_type cfg,
   input wire logic                 wdt_fail,
   input wire logic                 halted
);
   // ******
   // Idle time of the watchdog clock
   // ******
   logic [15:0] idle_reg;
   logic        pin_reg;
   wire logic   pw = bus_wr.wr && !bus_wr.sel_secondary;
   wire logic   wen = cfg.wdt_osc_en && cfg.fail_det_en;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pin_reg <= 1'b0;
      end else begin
         pin_reg <= wdt_clk_pin;
      end
   end
   // Counts from the raw edge, so sync delay only adds margin
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         idle_reg <= '0;
      end else if (!wen || (wdt_clk_pin && !pin_reg)) begin
         idle_reg <= '0;
      end else if (idle_reg != 16'hFFFF) begin
         idle_reg <= idle_reg + 16'h1;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   sequence s_pw(d); pw && bus_wr.data == d; endsequence
   sequence s_done; $changed(osc_control_primary) ##0 pw; endsequence
   property p_pri; $changed(osc_control_primary) |-> $past(pw); endproperty
   property p_unl;
      $changed(osc_control_primary) ##0 s_pw(8'hE7) ##1 s_pw(8'h18) ##1 pw
      |=> osc_control_primary == $past(bus_wr.data);
   endproperty
   property p_relock; s_done |=> $stable(osc_control_primary); endproperty
   property p_rev;
      $changed(osc_control_primary) ##0 s_pw(8'h18) ##1 s_pw(8'hE7) ##1 pw
      |=> $stable(osc_control_primary);
   endproperty
   property p_cfg;
      cfg == {osc_control_primary[7:4], osc_control_primary[2:0],
              osc_control_secondary[7]};
   endproperty
   property p_fmin; $rose(wdt_fail) |-> idle_reg >= FAIL_CYCLES - 1; endproperty
   property p_fmax; wen && idle_reg == FAIL_CYCLES + 6 |-> wdt_fail; endproperty
   property p_hcause;
      disable iff (!por_n) $rose(halted) |-> !$past(cfg.fail_det_en);
   endproperty
   property p_hkeep; disable iff (!por_n) halted |=> halted; endproperty
   a_pri: assert property (p_pri) else $error("stray update");
   a_unl: assert property (p_unl) else $error("unlock bad");
   a_relock: assert property (p_relock) else $error("no relock");
   a_rev: assert property (p_rev) else $error("reverse opened");
   a_cfg: assert property (p_cfg) else $error("cfg map");
   a_fmin: assert property (p_fmin) else $error("fail early");
   a_fmax: assert property (p_fmax) else $error("fail late");
   a_hcause: assert property (p_hcause) else $error("bad halt");
   a_hkeep: assert property (p_hkeep) else $error("halt lost");
endmodule : occ_top_sva

bind occ_top occ_top_sva #(.FAIL_CYCLES(FAIL_CYCLES)) u_sva (
   .core_clk(core_clk), .resetn(resetn), .por_n(por_n), .bus_wr(bus_wr),
   .wdt_clk_pin(wdt_clk_pin), .osc_control_primary(osc_control_primary),
   .osc_control_secondary(osc_control_secondary), .cfg(cfg),
   .wdt_fail(wdt_fail), .halted(halted));

/* testbench/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, resetn = 1'b0, por_n = 1'b0, wdt_clk_pin = 1'b0;
   logic periph_clk_pin = 1'b0, stop_mode = 1'b0, timer_periph_sel = 1'b0;
   occ_pkg::occ_wr_type  bus_wr = '0;
   occ_pkg::occ_cfg_type cfg;
   logic [7:0] pri, sec, pp, ps, r;
   logic [7:0] cur[2] = '{occ_pkg::PRIMARY_RESET, occ_pkg::SECONDARY_RESET};
   logic       wdt_fail, halted, tick, tclk, rec;
   logic       int_ok = 1'b1;
   logic [8:0] exp_q[$];
   int         failures = 0, checked = 0, n, m;
   initial forever #5 core_clk = ~core_clk;
   occ_top #(.FAIL_CYCLES(20)) dut (.core_clk(core_clk), .resetn(resetn),
      .por_n(por_n), .bus_wr(bus_wr), .wdt_clk_pin(wdt_clk_pin),
      .ext_osc_ok(1'b1), .int_osc_ok(int_ok), .stop_mode(stop_mode),
      .timer_periph_sel(timer_periph_sel), .periph_clk_pin(periph_clk_pin),
      .osc_control_primary(pri), .osc_control_secondary(sec), .cfg(cfg),
      .wdt_fail(wdt_fail), .recover_active(rec), .halted(halted),
      .timer_periph_tick(tick), .timer_clk_enable(tclk));
   // ******
   // Checking and closing
   // ******
   task automatic chk_reg(input logic [8:0] got, input logic [8:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: value %h, want %h", $time, got, exp);
      end
   endtask : chk_reg
   // Empty queue yields unknown, so a stray update always mismatches
   function automatic logic [8:0] next_exp();
      return (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
   endfunction : next_exp
   task automatic chk_bit(input logic got, input logic exp);
      chk_reg({8'h00, got}, {8'h00, exp});
   endtask : chk_bit
   task automatic give_verdict;
      if (failures == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict
   // ******
   // Write driver
   // ******
   task automatic wr(input logic s, input logic [7:0] d);
      @(posedge core_clk);
      #1 bus_wr = '{1'b1, s, d};
   endtask : wr
   task automatic idle(input int k);
      @(posedge core_clk);
      #1 bus_wr.wr = 1'b0;
      repeat (k) @(posedge core_clk);
   endtask : idle
   task automatic put(input logic s, input logic [7:0] d);
      if (d != cur[s]) exp_q.push_back({s, d});
      cur[s] = d;
   endtask : put
   task automatic commit(input logic s, input logic [7:0] d);
      wr(s, 8'hE7);
      wr(s, 8'h18);
      wr(s, d);
      put(s, d);
   endtask : commit
   // Every register change must match the oldest pending write
   initial forever begin
      @(posedge core_clk);
      #2;
      if (resetn === 1'b1 && pri !== pp) begin
         chk_reg({1'b0, pri}, next_exp());
      end
      if (resetn === 1'b1 && sec !== ps) begin
         chk_reg({1'b1, sec}, next_exp());
      end
      pp = pri;
      ps = sec;
   end
   initial begin
      #100000;
      failures++;
      give_verdict();
   end
   initial begin
      r = 8'($urandom(32'h5E45));
      repeat (3) @(posedge core_clk);
      #1 resetn = 1'b1;
      por_n = 1'b1;
      chk_reg({1'b0, pri}, {1'b0, occ_pkg::PRIMARY_RESET});
      chk_reg({1'b1, sec}, {1'b1, occ_pkg::SECONDARY_RESET});
      wr(1'b0, 8'h55);
      wr(1'b0, 8'h18);
      wr(1'b0, 8'hE7);
      wr(1'b0, 8'h44);
      repeat (8) begin
         r = 8'($urandom);
         commit(r[0], r[0] ? r : (8'h80 | (r & 8'h4F)));
      end
      commit(1'b0, 8'hA1);
      commit(1'b0, 8'hA2);
      wr(1'b0, 8'h18);
      wr(1'b0, 8'hE7);
      wr(1'b0, 8'h66);
      wr(1'b0, 8'hE7);
      wr(1'b1, 8'hE7);
      wr(1'b0, 8'h18);
      wr(1'b1, 8'h18);
      wr(1'b0, 8'h8A);
      put(1'b0, 8'h8A);
      wr(1'b1, 8'h80);
      put(1'b1, 8'h80);
      idle(3);
      #1 stop_mode = 1'b1;
      timer_periph_sel = 1'b1;
      n = 0;
      m = 0;
      for (int i = 0; i < 50; i++) begin
         @(posedge core_clk);
         #1 if (i % 5 == 0 && i < 40) periph_clk_pin = ~periph_clk_pin;
         n += tick;
         m += tick & tclk;
      end
      chk_reg(9'(n), 9'h004);
      chk_reg(9'(m), 9'h004);
      timer_periph_sel = 1'b0;
      #1 chk_bit(tclk, 1'b0);
      commit(1'b0, 8'hB0);
      idle(2);
      repeat (30) @(posedge core_clk) #1 wdt_clk_pin = ~wdt_clk_pin;
      chk_bit(wdt_fail, 1'b0);
      // Watchdog oscillator already running before it is selected
      commit(1'b0, 8'hB3);
      idle(0);
      wdt_clk_pin = 1'b0;
      repeat (13) @(posedge core_clk);
      #1 chk_bit(wdt_fail, 1'b0);
      chk_bit(rec, 1'b0);
      repeat (12) @(posedge core_clk);
      #1 chk_bit(wdt_fail, 1'b1);
      chk_bit(rec, 1'b1);
      repeat (8) @(posedge core_clk) #1 wdt_clk_pin = ~wdt_clk_pin;
      chk_bit(wdt_fail, 1'b0);
      chk_bit(rec, 1'b0);
      commit(1'b0, 8'h00);
      idle(5);
      chk_bit(halted, 1'b1);
      // Open the lock, then reset: the next write must not store
      wr(1'b0, 8'hE7);
      wr(1'b0, 8'h18);
      idle(0);
      #1 resetn = 1'b0;
      idle(2);
      #1 resetn = 1'b1;
      chk_bit(halted, 1'b1);
      wr(1'b0, 8'h5A);
      idle(0);
      por_n = 1'b0;
      idle(2);
      #1 por_n = 1'b1;
      chk_bit(halted, 1'b0);
      int_ok = 1'b0;
      commit(1'b0, 8'h80);
      idle(4);
      chk_bit(halted, 1'b1);
      chk_reg(9'(exp_q.size()), 9'h000);
      give_verdict();
   end
endmodule : tb_top
